//--- src/bsl_regs.vh
// Purpose: constants shared by the boundary-scan test logic
// Assumes: plain Verilog-2005, included by bare name
// Notes: pin counts of the boundary chain are a reduced generic set
`ifndef BSL_REGS_VH
`define BSL_REGS_VH

// instruction register
`define BSL_IR_W 4
`define BSL_IR_CAPTURE 4'hd
`define BSL_OP_EXTEST 4'h0
`define BSL_OP_SAMPLE 4'h1
`define BSL_OP_BYPASS 4'hf
`define BSL_OP_IDCODE 4'h5

// boundary chain layout: inputs first, then data/control pairs per bidir pin
`define BSL_N_IN 4
`define BSL_N_IO 4
`define BSL_CHAIN_LEN 12
`define BSL_IO_BASE 4

// input synchroniser depth
`define BSL_SYNC_STAGES 2

`endif

//--- src/bsl_sync.v
// Purpose: two-flop synchroniser for levels from outside the clock domain
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module bsl_sync #(
  parameter W = 1
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // data
  input wire [W-1:0] i_d,
  output reg [W-1:0] o_q
);

  reg [W-1:0] meta;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= {W{1'b0}};
      o_q <= {W{1'b0}};
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end

endmodule // bsl_sync

//--- src/bsl_bscell.v
// Purpose: one boundary-scan cell, master stage plus update stage
// Assumes: edge strobes are one-cycle pulses on i_clk
// Notes: master moves on test-clock rise, slave on test-clock fall
`timescale 1ns/1ps
module bsl_bscell (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // test-clock edges and controls
  input wire i_rise,
  input wire i_fall,
  input wire i_capture,
  input wire i_shift,
  input wire i_update,
  // data
  input wire i_par,
  input wire i_ser,
  output reg o_master,
  output reg o_slave
);

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_master <= 1'b0;
      o_slave <= 1'b0;
    end else begin
      if (i_rise && i_capture) begin
        o_master <= i_par; // see RQ18
      end else if (i_rise && i_shift) begin
        o_master <= i_ser; // see RQ15
      end
      if (i_fall && i_update) begin
        o_slave <= o_master; // see RQ13 see RQ19
      end
    end
  end

endmodule // bsl_bscell

//--- src/bsl_tap_top.v
// Purpose: boundary-scan test port: tap controller, instruction register,
//   bypass register and boundary chain around a set of system pins
// Assumes: test clock is a slow pin sampled by i_clk (250 MHz)
// Notes: test-clock edges are seen three i_clk cycles late
//
// Function
// RQ1 - 4-bit instruction register with shift master and latched slave stage
// RQ2 - selected instruction register shifts from TDI toward TDO per TCK rise
// RQ3 - new instruction acts only at master-to-slave transfer, old one stops
// RQ4 - TDI enters instruction MSB, instruction LSB drives TDO
// RQ5 - capture loads 1101, shifted out LSB first
// RQ6 - TRST# low asynchronously forces the id code instruction
// RQ7 - new opcode becomes active on TCK falling edge
// RQ8 - decode 0000 extest, 0001 sample/preload, 1111 bypass
// RQ9 - test master never loads reserved opcode 0101
// RQ10 - extest: boundary chain on TDO, outputs from cells, change on fall
// RQ11 - extest: system input pins captured on TCK rise
// RQ12 - sample: snapshot on rise, outputs cells sample driven values
// RQ13 - sample: master cells copied into slave cells on TCK fall
// RQ14 - bypass: one-bit register on TDO, system operation undisturbed
// RQ15 - data register TDI at MSB, TDO from LSB, one shift per rise
// RQ16 - one cell per pin plus control cells, control 0 means high-z
// RQ17 - supply, pll, analog and test pins stay out of the chain
// RQ18 - parallel load of boundary master cells on TCK rise
// RQ19 - serially loaded master data applied to pins on TCK fall
// RQ20 - TDO changes on falling TCK edges
// RQ21 - tap moves on TCK rise by TMS; TRST# or five TMS highs reset
// RQ22 - power-on reset puts tap in test-logic-reset
// RQ23 - undecoded opcodes, reserved one included, select the bypass register
`timescale 1ns/1ps
`include "bsl_regs.vh"
module bsl_tap_top (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // test port pins
  input wire i_tck,
  input wire i_tms,
  input wire i_tdi,
  input wire i_trst_n,
  output reg o_tdo,
  output reg o_tdo_oe,
  // system input pins and their path into the core
  input wire [`BSL_N_IN-1:0] i_pin_in,
  output reg [`BSL_N_IN-1:0] o_core_in,
  // bidir pins: core side
  input wire [`BSL_N_IO-1:0] i_core_out,
  input wire [`BSL_N_IO-1:0] i_core_oe,
  output reg [`BSL_N_IO-1:0] o_core_pad_in,
  // bidir pins: pad side
  input wire [`BSL_N_IO-1:0] i_pad_in,
  output reg [`BSL_N_IO-1:0] o_pad_out,
  output reg [`BSL_N_IO-1:0] o_pad_oe
);

  // one-hot tap states
  localparam [15:0] ST_TLR = 16'h0001;
  localparam [15:0] ST_RTI = 16'h0002;
  localparam [15:0] ST_SDS = 16'h0004;
  localparam [15:0] ST_CDR = 16'h0008;
  localparam [15:0] ST_SHDR = 16'h0010;
  localparam [15:0] ST_E1DR = 16'h0020;
  localparam [15:0] ST_PDR = 16'h0040;
  localparam [15:0] ST_E2DR = 16'h0080;
  localparam [15:0] ST_UDR = 16'h0100;
  localparam [15:0] ST_SIS = 16'h0200;
  localparam [15:0] ST_CIR = 16'h0400;
  localparam [15:0] ST_SHIR = 16'h0800;
  localparam [15:0] ST_E1IR = 16'h1000;
  localparam [15:0] ST_PIR = 16'h2000;
  localparam [15:0] ST_E2IR = 16'h4000;
  localparam [15:0] ST_UIR = 16'h8000;

  // tap and instruction state is also cleared by the test reset pin;
  // the pin acts without any clock edge, so it bypasses the synchroniser
  // limitation: its release is not synchronised either, so the master
  // should keep tck low for a few clocks around the rising edge of the pin
  wire tap_rst;
  assign tap_rst = i_rst | ~i_trst_n; // see RQ6 see RQ22

  // pin synchronisers
  wire [2:0] port_s;
  wire [`BSL_N_IN+`BSL_N_IO-1:0] pins_s;
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire [`BSL_N_IN-1:0] pin_in_s;
  wire [`BSL_N_IO-1:0] pad_in_s;

  bsl_sync #(.W(3)) u_port_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_tck, i_tms, i_tdi}),
    .o_q(port_s)
  );

  bsl_sync #(.W(`BSL_N_IN + `BSL_N_IO)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_d({i_pad_in, i_pin_in}),
    .o_q(pins_s)
  );

  assign tck_s = port_s[2];
  assign tms_s = port_s[1];
  assign tdi_s = port_s[0];
  assign pin_in_s = pins_s[`BSL_N_IN-1:0];
  assign pad_in_s = pins_s[`BSL_N_IN+`BSL_N_IO-1:`BSL_N_IN];

  // test-clock edge detection on the synchronised copy
  reg tck_d;
  wire tck_rise;
  wire tck_fall;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d;
  assign tck_fall = ~tck_s & tck_d;

  // tap controller
  reg [15:0] state;
  reg [15:0] next_state;

  always @* begin
    case (state)
      ST_TLR: next_state = tms_s ? ST_TLR : ST_RTI;
      ST_RTI: next_state = tms_s ? ST_SDS : ST_RTI;
      ST_SDS: next_state = tms_s ? ST_SIS : ST_CDR;
      ST_CDR: next_state = tms_s ? ST_E1DR : ST_SHDR;
      ST_SHDR: next_state = tms_s ? ST_E1DR : ST_SHDR;
      ST_E1DR: next_state = tms_s ? ST_UDR : ST_PDR;
      ST_PDR: next_state = tms_s ? ST_E2DR : ST_PDR;
      ST_E2DR: next_state = tms_s ? ST_UDR : ST_SHDR;
      ST_UDR: next_state = tms_s ? ST_SDS : ST_RTI;
      ST_SIS: next_state = tms_s ? ST_TLR : ST_CIR;
      ST_CIR: next_state = tms_s ? ST_E1IR : ST_SHIR;
      ST_SHIR: next_state = tms_s ? ST_E1IR : ST_SHIR;
      ST_E1IR: next_state = tms_s ? ST_UIR : ST_PIR;
      ST_PIR: next_state = tms_s ? ST_E2IR : ST_PIR;
      ST_E2IR: next_state = tms_s ? ST_UIR : ST_SHIR;
      ST_UIR: next_state = tms_s ? ST_SDS : ST_RTI;
      default: next_state = ST_TLR;
    endcase
  end

  // five rising edges with tms high reach test-logic-reset from any state
  always @(posedge i_clk or posedge tap_rst) begin
    if (tap_rst) begin
      state <= ST_TLR;
    end else if (tck_rise) begin
      state <= next_state; // see RQ21
    end
  end

  // instruction register: shift stage and latched stage
  reg [`BSL_IR_W-1:0] ir_shift;
  reg [`BSL_IR_W-1:0] ir_active;

  always @(posedge i_clk or posedge tap_rst) begin
    if (tap_rst) begin
      ir_shift <= `BSL_IR_CAPTURE;
    end else if (tck_rise) begin
      if (state == ST_CIR) begin
        ir_shift <= `BSL_IR_CAPTURE; // see RQ5
      end else if (state == ST_SHIR) begin
        ir_shift <= {tdi_s, ir_shift[`BSL_IR_W-1:1]}; // see RQ1 see RQ2 see RQ4
      end
    end
  end

  // the latched opcode only moves here, so a half-shifted opcode never acts
  always @(posedge i_clk or posedge tap_rst) begin
    if (tap_rst) begin
      ir_active <= `BSL_OP_IDCODE; // see RQ6
    end else if (tck_fall) begin
      if (state == ST_TLR) begin
        ir_active <= `BSL_OP_IDCODE;
      end else if (state == ST_UIR) begin
        ir_active <= ir_shift; // see RQ3 see RQ7
      end
    end
  end

  // decode; the id code and every other undecoded opcode fall to bypass
  wire op_extest;
  wire op_sample;
  wire op_bsr;
  wire op_bypass;

  assign op_extest = (ir_active == `BSL_OP_EXTEST); // see RQ8
  assign op_sample = (ir_active == `BSL_OP_SAMPLE); // see RQ8
  assign op_bsr = op_extest | op_sample;
  assign op_bypass = ~op_bsr; // see RQ23 see RQ9

  // bypass register
  reg bypass_bit;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bypass_bit <= 1'b0;
    end else if (tck_rise && op_bypass) begin
      if (state == ST_CDR) begin
        bypass_bit <= 1'b0;
      end else if (state == ST_SHDR) begin
        bypass_bit <= tdi_s; // see RQ14
      end
    end
  end

  // boundary chain; supply, pll, analog and test pins have no cell
  // see RQ17 see RQ16
  wire [`BSL_CHAIN_LEN-1:0] cell_par;
  wire [`BSL_CHAIN_LEN-1:0] cell_master;
  wire [`BSL_CHAIN_LEN-1:0] cell_slave;
  wire [`BSL_CHAIN_LEN-1:0] cell_ser;
  wire bsr_capture;
  wire bsr_shift;
  wire bsr_update;
  wire [`BSL_N_IN-1:0] upd_in;
  wire [`BSL_N_IO-1:0] upd_data;
  wire [`BSL_N_IO-1:0] upd_ctrl;

  assign bsr_capture = op_bsr & (state == ST_CDR); // see RQ11 see RQ12
  assign bsr_shift = op_bsr & (state == ST_SHDR);
  assign bsr_update = op_bsr & (state == ST_UDR);
  assign cell_ser = {tdi_s, cell_master[`BSL_CHAIN_LEN-1:1]}; // see RQ15

  genvar gi;
  generate
    for (gi = 0; gi < `BSL_N_IN; gi = gi + 1) begin : g_in
      assign cell_par[gi] = pin_in_s[gi]; // see RQ11
      assign upd_in[gi] = cell_slave[gi];
    end
    for (gi = 0; gi < `BSL_N_IO; gi = gi + 1) begin : g_io
      // a driven pin samples the driven value, otherwise the pad level
      assign cell_par[`BSL_IO_BASE+2*gi] = i_core_oe[gi] ? i_core_out[gi] : pad_in_s[gi]; // see RQ12
      assign cell_par[`BSL_IO_BASE+2*gi+1] = i_core_oe[gi];
      assign upd_data[gi] = cell_slave[`BSL_IO_BASE+2*gi];
      assign upd_ctrl[gi] = cell_slave[`BSL_IO_BASE+2*gi+1];
    end
    for (gi = 0; gi < `BSL_CHAIN_LEN; gi = gi + 1) begin : g_cell
      bsl_bscell u_cell (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_rise(tck_rise),
        .i_fall(tck_fall),
        .i_capture(bsr_capture),
        .i_shift(bsr_shift),
        .i_update(bsr_update),
        .i_par(cell_par[gi]),
        .i_ser(cell_ser[gi]),
        .o_master(cell_master[gi]),
        .o_slave(cell_slave[gi])
      );
    end
  endgenerate

  // serial output, moved only on the falling test-clock edge
  // enable drops outside shift states so a shared scan line is left free
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      if (state == ST_SHIR) begin
        o_tdo <= ir_shift[0]; // see RQ4 see RQ5 see RQ20
        o_tdo_oe <= 1'b1;
      end else if (state == ST_SHDR) begin
        o_tdo <= op_bypass ? bypass_bit : cell_master[0]; // see RQ10 see RQ14 see RQ20
        o_tdo_oe <= 1'b1;
      end else begin
        o_tdo_oe <= 1'b0;
      end
    end
  end

  // pin muxes; slaves only move on falls, so extest pins change on falls
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_core_in <= {`BSL_N_IN{1'b0}};
      o_core_pad_in <= {`BSL_N_IO{1'b0}};
      o_pad_out <= {`BSL_N_IO{1'b0}};
      o_pad_oe <= {`BSL_N_IO{1'b0}};
    end else if (op_extest) begin
      o_core_in <= upd_in; // see RQ19
      o_core_pad_in <= upd_data;
      o_pad_out <= upd_data; // see RQ10
      o_pad_oe <= upd_ctrl; // see RQ16
    end else begin
      o_core_in <= pin_in_s; // see RQ14 see RQ12
      o_core_pad_in <= pad_in_s;
      o_pad_out <= i_core_out;
      o_pad_oe <= i_core_oe;
    end
  end

endmodule // bsl_tap_top

//--- verification/bsl_tap_props.sv
// Purpose: timing checks on the boundary-scan test port pins
// Assumes: test clock is slow against i_clk
// Notes: outputs may move only shortly after a tck fall or an input change
`timescale 1ns/1ps
`include "bsl_regs.vh"
module bsl_tap_props (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // test port
  input wire i_tck,
  input wire i_trst_n,
  input wire o_tdo,
  input wire o_tdo_oe,
  // system pins
  input wire [`BSL_N_IN-1:0] i_pin_in,
  input wire [`BSL_N_IN-1:0] o_core_in,
  input wire [`BSL_N_IO-1:0] i_core_out,
  input wire [`BSL_N_IO-1:0] i_core_oe,
  input wire [`BSL_N_IO-1:0] i_pad_in,
  input wire [`BSL_N_IO-1:0] o_pad_out,
  input wire [`BSL_N_IO-1:0] o_pad_oe
);
  reg tck_q;
  reg [15:0] in_q;
  reg [7:0] cf;
  reg [7:0] cq;
  wire [15:0] in_now = {i_pin_in, i_core_out, i_core_oe, i_pad_in};
  // cf counts cycles since tck fell, cq since another input moved
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tck_q <= 1'b0;
      in_q <= 16'h0;
      cf <= 8'h0;
      cq <= 8'h0;
    end else begin
      tck_q <= i_tck;
      in_q <= in_now;
      if (tck_q && !i_tck)
        cf <= 8'h0;
      else if (cf != 8'hff)
        cf <= cf + 8'h01;
      if (in_q != in_now || !i_trst_n)
        cq <= 8'h0;
      else if (cq != 8'hff)
        cq <= cq + 8'h01;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_tdo_fall;
    $changed(o_tdo) |-> cf <= 8'h0a;
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a tck fall");
  property p_tdo_hold;
    $changed(o_tdo) |=> $stable(o_tdo)[*8];
  endproperty
  a_tdo_hold: assert property (p_tdo_hold) else $error("tdo did not stand");
  property p_tdo_oe_on;
    $changed(o_tdo) |-> o_tdo_oe;
  endproperty
  a_tdo_oe_on: assert property (p_tdo_oe_on) else $error("tdo moved while not driven");
  property p_oe_fall;
    $changed(o_tdo_oe) |-> cf <= 8'h0a;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("tdo enable moved off a fall");
  property p_pad_oe_fall;
    $changed(o_pad_oe) |-> cf <= 8'h0a || cq <= 8'h06;
  endproperty
  a_pad_oe_fall: assert property (p_pad_oe_fall) else $error("pad enable moved");
  property p_pad_oe_hold;
    $changed(o_pad_oe) |=> $stable(o_pad_oe)[*4];
  endproperty
  a_pad_oe_hold: assert property (p_pad_oe_hold) else $error("pad enable glitch");
  property p_pad_out_fall;
    $changed(o_pad_out) |-> cf <= 8'h0a || cq <= 8'h06;
  endproperty
  a_pad_out_fall: assert property (p_pad_out_fall) else $error("pad data moved");
  property p_core_in_fall;
    $changed(o_core_in) |-> cf <= 8'h0a || cq <= 8'h06;
  endproperty
  a_core_in_fall: assert property (p_core_in_fall) else $error("core input moved");
  property p_trst_pads;
    (!i_trst_n)[*4] |-> o_pad_oe == $past(i_core_oe) && o_pad_out == $past(i_core_out);
  endproperty
  a_trst_pads: assert property (p_trst_pads) else $error("test reset left pads");
endmodule // bsl_tap_props

//--- verification/bsl_tm.sv
// Purpose: test master model driving the tap pins
// Assumes: tasks are entered and left on a rising i_clk edge
// Notes: tck stands low between scans, 40 clk per test-clock period
`timescale 1ns/1ps
module bsl_tm (
  // clock
  input wire i_clk,
  // tap pins
  input wire i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_trst_n = 1'b1;
  end
  // tms and tdi change while tck is low, tdo taken at the rise
  task step(input logic tms, input logic tdi, output logic tdo_s);
    begin
      o_tms <= tms;
      o_tdi <= tdi;
      repeat (20) @(posedge i_clk);
      tdo_s = i_tdo;
      o_tck <= 1'b1;
      repeat (20) @(posedge i_clk);
      o_tck <= 1'b0;
    end
  endtask
  // only opcodes 0000, 0001 and 1111 are ever sent
  task scan(input logic ir, input logic [15:0] din, input int n, output logic [15:0] dout);
    logic t;
    int i;
    begin
      dout = 16'h0;
      step(1'b0, 1'b0, t);
      step(1'b1, 1'b0, t);
      if (ir)
        step(1'b1, 1'b0, t);
      step(1'b0, 1'b0, t);
      step(1'b0, 1'b0, t);
      for (i = 0; i < n; i++) begin
        step(i == n - 1, din[i], t);
        dout[i] = t;
      end
      step(1'b1, 1'b0, t);
      step(1'b0, 1'b0, t);
    end
  endtask
  task five_high;
    logic t;
    begin
      repeat (5) step(1'b1, 1'b0, t);
    end
  endtask
  task set_trst(input logic v);
    begin
      o_trst_n <= v;
      @(posedge i_clk);
    end
  endtask
endmodule // bsl_tm

//--- verification/bsl_tb.sv
// Purpose: self-checking bench for the boundary-scan test port
// Assumes: bsl_tm plays the test master
// Notes: scan results follow the 12-cell chain layout
`timescale 1ns/1ps
`include "bsl_regs.vh"
module testbench;
  reg i_clk;
  reg i_rst;
  wire tck, tms, tdi, trst_n, tdo, tdo_oe;
  reg [3:0] pin_in, core_out, core_oe, board;
  wire [3:0] core_in, core_pad_in, pad_out, pad_oe;
  // pad level: our driver where enabled, else the board
  wire [3:0] pad_in = (pad_oe & pad_out) | (~pad_oe & board);
  logic [15:0] d;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  bsl_tap_top u_bsl_tap_top (.i_clk(i_clk), .i_rst(i_rst), .i_tck(tck), .i_tms(tms),
    .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pin_in(pin_in),
    .o_core_in(core_in), .i_core_out(core_out), .i_core_oe(core_oe),
    .o_core_pad_in(core_pad_in), .i_pad_in(pad_in), .o_pad_out(pad_out), .o_pad_oe(pad_oe));
  bsl_tm u_bsl_tm (.i_clk(i_clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
    .o_trst_n(trst_n));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task print_verdict;
    begin
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict;
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      checks++;
      if (seen !== exp) begin
        bad_count++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task set_pins(input logic [3:0] p, input logic [3:0] co, input logic [3:0] oe);
    begin
      pin_in <= p;
      core_out <= co;
      core_oe <= oe;
      repeat (8) @(posedge i_clk);
    end
  endtask
  task t_bypass;
    begin
      u_bsl_tm.scan(1'b0, 16'h0016, 5, d);
      check(d[4:0], 5'h0c);
      check(pad_out, core_out);
      check(pad_oe, core_oe);
    end
  endtask
  task t_ir_capture;
    begin
      u_bsl_tm.scan(1'b1, 16'h000f, 4, d);
      check(d[3:0], 4'hd);
      check(tdo_oe, 1'b0);
      t_bypass;
    end
  endtask
  task t_sample;
    begin
      set_pins(4'ha, 4'h6, 4'hf);
      u_bsl_tm.scan(1'b1, 16'h0001, 4, d);
      u_bsl_tm.scan(1'b0, 16'h01e9, 12, d);
      check(d[3:0], 4'ha);
      check({d[10], d[8], d[6], d[4]}, 4'h6);
      check(pad_out, 4'h6);
    end
  endtask
  task t_extest;
    begin
      u_bsl_tm.scan(1'b1, 16'h0000, 4, d);
      check(pad_oe, 4'h3);
      check(pad_out[1:0], 2'h2);
      check(core_in, 4'h9);
      check(core_pad_in, 4'h6);
      set_pins(4'h5, 4'h6, 4'hf);
      u_bsl_tm.scan(1'b0, 16'h01e6, 12, d);
      check(d[3:0], 4'h5);
      check(core_in, 4'h6);
    end
  endtask
  task t_trst;
    begin
      u_bsl_tm.set_trst(1'b0);
      repeat (4) @(posedge i_clk);
      check(pad_oe, core_oe);
      check(core_in, pin_in);
      u_bsl_tm.set_trst(1'b1);
      t_bypass;
    end
  endtask
  task t_tms_reset;
    begin
      u_bsl_tm.scan(1'b1, 16'h0000, 4, d);
      check(pad_oe, 4'h3);
      u_bsl_tm.five_high;
      repeat (8) @(posedge i_clk);
      check(pad_oe, core_oe);
    end
  endtask
  initial begin
    i_rst = 1'b1;
    pin_in = 4'h3;
    core_out = 4'h9;
    core_oe = 4'hc;
    board = 4'ha;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (8) @(posedge i_clk);
    t_bypass;
    t_ir_capture;
    t_sample;
    t_extest;
    t_trst;
    t_tms_reset;
    print_verdict;
  end
endmodule // testbench
bind bsl_tap_top bsl_tap_props u_bsl_tap_props (.i_clk(i_clk), .i_rst(i_rst), .i_tck(i_tck),
  .i_trst_n(i_trst_n), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_pin_in(i_pin_in),
  .o_core_in(o_core_in), .i_core_out(i_core_out), .i_core_oe(i_core_oe),
  .i_pad_in(i_pad_in), .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe));
